// >>> rtl/feg_core.v
// Floating-point exception gating: flags, masks, waiting check, bus.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "feg_consts.vh"

// All inputs come from logic on this clock, so none is synchronised.
// The register port answers in the cycle after the strobe and never inserts wait states.
module feg_core (
    input wire clock,
    input wire rst,
    // Instruction presented by the integer core.
    input wire issueValid,
    input wire [`FEG_OP_W-1:0] issueOp,
    input wire [1:0] memFmt,
    input wire pushDst,
    input wire [1:0] dstTag,
    input wire checkSrc,
    input wire [1:0] srcTag,
    input wire [`FEG_NEXC-1:0] numExc,
    input wire [`FEG_DW-1:0] loadCtrl,
    input wire [`FEG_DW-1:0] loadStat,
    // Register port.
    input wire [`FEG_AW-1:0] regAddr,
    input wire [`FEG_DW-1:0] regWdata,
    input wire regWr,
    input wire regRd,
    // Answers to the integer core.
    output reg issueDone_q,
    output reg commit_q,
    output reg excPending_q,
    output reg handlerReq_q,
    output reg arithClass_q,
    output reg storeValid_q,
    output reg [`FEG_DW-1:0] storeCtrl_q,
    output reg [`FEG_DW-1:0] storeStat_q,
    // Register read data and interrupt.
    output reg [`FEG_DW-1:0] regRdata_q,
    output reg irq_q
);

    // ==========================================================
    // State
    // Flags, masks, the stack flag and condition bit one are the
    // architectural words; the summary is a registered copy of the
    // unmasked flags so that the gate below sees a settled value.
    // The event registers belong to the register port only.
    // Architectural words and their next values.
    reg [`FEG_NEXC-1:0] flags_q;
    reg [`FEG_NEXC-1:0] flags_d;
    reg [`FEG_NEXC-1:0] masks_q;
    reg [`FEG_NEXC-1:0] masks_d;
    reg stackFault_q;
    reg stackFault_d;
    reg condOne_q;
    reg condOne_d;
    reg summary_q;
    // Register port state.
    reg compat_q;
    reg [`FEG_NEVT-1:0] evt_q;
    reg [`FEG_NEVT-1:0] evtMask_q;
    // Decoded and derived terms.
    wire isWaiting;
    wire isNop;
    wire isArith;
    wire overflowHit;
    wire underflowHit;
    wire stackHit;
    wire [`FEG_NEXC-1:0] rawExc;
    wire [`FEG_NEXC-1:0] newExc;
    wire invalidUnmasked;
    wire blocked;
    wire proceed;
    wire summaryNext;
    wire [`FEG_DW-1:0] ctrlWord;
    wire [`FEG_DW-1:0] statWord;
    reg [`FEG_NEVT-1:0] evtSet;

    // ==========================================================
    // Classifier
    // The decoder is purely combinational; its outputs are valid in
    // the cycle that the instruction is presented and are only used
    // while issueValid is high.
    feg_class u_class (
        .op(issueOp),
        .memFmt(memFmt),
        .isWaiting(isWaiting),
        .isNop(isNop),
        .isArith(isArith)
    );

    // ==========================================================
    // Stack and numeric exception detection
    // The tag inputs describe the register that the instruction
    // pushes into or sources from. A stack fault is not a result of
    // operand processing, so non-arithmetic kinds may raise it too.
    // Datapath flags of a non-arithmetic kind are dropped here.
    // A push onto a non-empty register overflows the stack.
    assign overflowHit = pushDst && (dstTag != `FEG_TAG_EMPTY);
    // Sourcing an empty register underflows it.
    assign underflowHit = checkSrc && srcTag == `FEG_TAG_EMPTY;
    // Either fault counts as the stack subclass of invalid.
    assign stackHit = overflowHit || underflowHit;
    // Only arithmetic instructions pass datapath exceptions on.
    assign rawExc = isArith ? numExc : {`FEG_NEXC{1'b0}};
    // All six classes, with the stack fault folded into invalid.
    assign newExc = rawExc |
        ({{(`FEG_NEXC-1){1'b0}}, stackHit} << `FEG_BIT_INVALID);
    // An unmasked invalid of either subclass calls the handler.
    assign invalidUnmasked = newExc[`FEG_BIT_INVALID] &&
        !masks_q[`FEG_BIT_INVALID];

    // ==========================================================
    // Gating of the issued instruction
    // The check looks at the summary as it stood before this edge, so
    // an instruction that raises a new unmasked exception is not held
    // itself; the next waiting instruction is. A stalled instruction
    // must be reissued by the core once the handler has run.
    // A waiting instruction is held while the summary flag is set.
    assign blocked = issueValid && isWaiting && summary_q;
    // Non-waiting forms ignore the summary even in compatibility mode.
    assign proceed = issueValid && !blocked;

    // ==========================================================
    // Next values of the architectural flags and masks
    // Only an instruction that proceeds and is not an obsolete no-op
    // touches the words. Loads replace them wholesale (the control load only the masks), clears
    // reset the flags and stack flag, saves other than XSAVE and initialisation reset all four, and every other kind adds new
    // events to the sticky flags and, on a stack fault, sets the stack flag and writes C1.
    always @* begin
        flags_d = flags_q;
        masks_d = masks_q;
        stackFault_d = stackFault_q;
        condOne_d = condOne_q;
        if (proceed && !isNop) begin
            case (issueOp)
                `FEG_OP_LDCW: begin
                    masks_d = loadCtrl[`FEG_NEXC-1:0];
                end
                `FEG_OP_LDENV, `FEG_OP_RSTOR, `FEG_OP_XRSTOR: begin
                    masks_d = loadCtrl[`FEG_NEXC-1:0];
                    flags_d = loadStat[`FEG_NEXC-1:0];
                    stackFault_d = loadStat[`FEG_BIT_SF];
                    condOne_d = loadStat[`FEG_BIT_C1];
                end
                `FEG_OP_INIT_W, `FEG_OP_INIT_N,
                `FEG_OP_SAVE_W, `FEG_OP_SAVE_N: begin
                    // Saving reinitialises once the old state is stored.
                    masks_d = `FEG_MASK_INIT;
                    flags_d = {`FEG_NEXC{1'b0}};
                    stackFault_d = 1'b0;
                    condOne_d = 1'b0;
                end
                `FEG_OP_CLEX_W, `FEG_OP_CLEX_N: begin
                    flags_d = {`FEG_NEXC{1'b0}};
                    stackFault_d = 1'b0;
                end
                default: begin
                    // Flags are sticky; new events only add to them.
                    flags_d = flags_q | newExc;
                    if (stackHit) begin
                        stackFault_d = 1'b1;
                        condOne_d = overflowHit;
                    end
                end
            endcase
        end
    end

    // Summary follows any flag whose mask is clear.
    // It is taken from the next values, so it moves on the same edge.
    assign summaryNext = |(flags_d & ~masks_d);

    // ==========================================================
    // Flag, mask and summary registers
    // Reset returns the unit to its initialised state; masks come up
    // set, so that no exception is unmasked after reset.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_q <= {`FEG_NEXC{1'b0}};
            masks_q <= `FEG_MASK_INIT;
            stackFault_q <= 1'b0;
            condOne_q <= 1'b0;
            summary_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            masks_q <= masks_d;
            stackFault_q <= stackFault_d;
            condOne_q <= condOne_d;
            summary_q <= summaryNext;
        end
    end

    // ==========================================================
    // Word images
    // The unused bits of both words read as zero, and bit 8 of the
    // status image is kept clear.
    // Invalid at bit 0 of both words, stack fault 6, summary 7, C1 9.
    assign ctrlWord = {{(`FEG_DW-`FEG_NEXC){1'b0}}, masks_q};
    assign statWord = {{(`FEG_DW-10){1'b0}}, condOne_q, 1'b0, summary_q,
        stackFault_q, flags_q};

    // ==========================================================
    // Answer to the integer core
    // Every answer is a single-cycle pulse that follows the presented
    // instruction by one edge. The stored words are levels that hold
    // until the next store of the same word, so the core may pick
    // them up at its leisure.
    // Stores sample the words before the issuing instruction alters them.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            issueDone_q <= 1'b0;
            commit_q <= 1'b0;
            excPending_q <= 1'b0;
            handlerReq_q <= 1'b0;
            arithClass_q <= 1'b0;
            storeValid_q <= 1'b0;
            storeCtrl_q <= {`FEG_DW{1'b0}};
            storeStat_q <= {`FEG_DW{1'b0}};
        end else begin
            issueDone_q <= proceed;
            // The stalled instruction updates nothing.
            excPending_q <= blocked;
            // Unmasked invalid keeps stack pointer and sources intact.
            handlerReq_q <= proceed && !isNop &&
                invalidUnmasked;
            commit_q <= proceed && !isNop && !invalidUnmasked;
            arithClass_q <= issueValid && isArith;
            storeValid_q <= 1'b0;
            if (proceed) begin
                case (issueOp)
                    `FEG_OP_STCW_W, `FEG_OP_STCW_N: begin
                        storeCtrl_q <= ctrlWord;
                        storeValid_q <= 1'b1;
                    end
                    `FEG_OP_STSW_W, `FEG_OP_STSW_N: begin
                        storeStat_q <= statWord;
                        storeValid_q <= 1'b1;
                    end
                    `FEG_OP_STENV_W, `FEG_OP_STENV_N, `FEG_OP_SAVE_W,
                    `FEG_OP_SAVE_N, `FEG_OP_XSAVE: begin
                        storeCtrl_q <= ctrlWord;
                        storeStat_q <= statWord;
                        storeValid_q <= 1'b1;
                    end
                    default: begin
                        storeValid_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Interrupt events
    // Events are taken from the same terms that drive the answer, so
    // software sees exactly what the core was told. A stall event
    // repeats for every reissue that is still held.
    // In compatibility mode a newly raised summary is also reported.
    always @* begin
        evtSet = {`FEG_NEVT{1'b0}};
        evtSet[`FEG_EV_STALL] = blocked;
        evtSet[`FEG_EV_STACK] = proceed && !isNop && stackHit;
        evtSet[`FEG_EV_HANDLER] = proceed && !isNop && invalidUnmasked;
        evtSet[`FEG_EV_NUMERIC] = (proceed && !isNop && (|rawExc)) ||
            (compat_q && summaryNext && !summary_q);
    end

    // ==========================================================
    // Register port and event registers
    // Writes to the status register and to unmapped offsets are
    // ignored. The interrupt lags the event bits by one cycle, since
    // it is registered.
    // A new event wins over a write-one-to-clear in the same cycle.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            compat_q <= 1'b0;
            evt_q <= {`FEG_NEVT{1'b0}};
            evtMask_q <= {`FEG_NEVT{1'b0}};
            irq_q <= 1'b0;
        end else begin
            if (regWr && (regAddr == `FEG_ADDR_CTRL)) begin
                compat_q <= regWdata[`FEG_BIT_COMPAT];
            end
            if (regWr && (regAddr == `FEG_ADDR_EVMSK)) begin
                evtMask_q <= regWdata[`FEG_NEVT-1:0];
            end
            if (regWr && (regAddr == `FEG_ADDR_EVT)) begin
                evt_q <= (evt_q & ~regWdata[`FEG_NEVT-1:0]) | evtSet;
            end else begin
                evt_q <= evt_q | evtSet;
            end
            irq_q <= |(evt_q & evtMask_q);
        end
    end

    // Read data stand in the cycle after the read strobe only.
    // Unmapped offsets read as zero, and the data return to zero
    // outside the answer cycle to keep the bus quiet.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata_q <= {`FEG_DW{1'b0}};
        end else if (regRd) begin
            case (regAddr)
                `FEG_ADDR_CTRL: begin
                    regRdata_q <= ctrlWord |
                        ({{(`FEG_DW-1){1'b0}}, compat_q} << `FEG_BIT_COMPAT);
                end
                `FEG_ADDR_STAT: begin
                    regRdata_q <= statWord;
                end
                `FEG_ADDR_EVT: begin
                    regRdata_q <= {{(`FEG_DW-`FEG_NEVT){1'b0}}, evt_q};
                end
                `FEG_ADDR_EVMSK: begin
                    regRdata_q <= {{(`FEG_DW-`FEG_NEVT){1'b0}}, evtMask_q};
                end
                default: begin
                    regRdata_q <= {`FEG_DW{1'b0}};
                end
            endcase
        end else begin
            regRdata_q <= {`FEG_DW{1'b0}};
        end
    end

endmodule // feg_core

// >>> rtl/feg_consts.vh
// Constants for the floating-point exception gating block.
`ifndef FEG_CONSTS_VH
`define FEG_CONSTS_VH

// ==========================================================
// Instruction kinds presented by the integer core
`define FEG_OP_W 5
`define FEG_OP_ARITH 5'h00
`define FEG_OP_NONARITH 5'h01
`define FEG_OP_WAITCHK 5'h02
`define FEG_OP_LDCW 5'h03
`define FEG_OP_STCW_W 5'h04
`define FEG_OP_STCW_N 5'h05
`define FEG_OP_STSW_W 5'h06
`define FEG_OP_STSW_N 5'h07
`define FEG_OP_STENV_W 5'h08
`define FEG_OP_STENV_N 5'h09
`define FEG_OP_SAVE_W 5'h0A
`define FEG_OP_SAVE_N 5'h0B
`define FEG_OP_INIT_W 5'h0C
`define FEG_OP_INIT_N 5'h0D
`define FEG_OP_CLEX_W 5'h0E
`define FEG_OP_CLEX_N 5'h0F
`define FEG_OP_LDENV 5'h10
`define FEG_OP_RSTOR 5'h11
`define FEG_OP_XRSTOR 5'h12
`define FEG_OP_XSAVE 5'h13
`define FEG_OP_LEG_ENI 5'h14
`define FEG_OP_LEG_DISI 5'h15
`define FEG_OP_LEG_SETPM 5'h16
`define FEG_OP_MOVE 5'h17

// ==========================================================
// Operand format of a move
`define FEG_FMT_REG 2'h0
`define FEG_FMT_SGLDBL 2'h1
`define FEG_FMT_EXT 2'h2
`define FEG_FMT_INTBCD 2'h3

// ==========================================================
// Tag, status and control word layout
`define FEG_TAG_EMPTY 2'h3
`define FEG_NEXC 6
`define FEG_BIT_INVALID 0
`define FEG_BIT_SF 6
`define FEG_BIT_ES 7
`define FEG_BIT_C1 9
`define FEG_BIT_COMPAT 8
`define FEG_MASK_INIT 6'h3F

// ==========================================================
// Register offsets and event bits
`define FEG_AW 4
`define FEG_DW 16
`define FEG_ADDR_CTRL 4'h0
`define FEG_ADDR_STAT 4'h1
`define FEG_ADDR_EVT 4'h2
`define FEG_ADDR_EVMSK 4'h3
`define FEG_NEVT 4
`define FEG_EV_STALL 0
`define FEG_EV_STACK 1
`define FEG_EV_HANDLER 2
`define FEG_EV_NUMERIC 3

`endif

// >>> rtl/feg_class.v
// Instruction classifier: waiting form, no-operation and arithmetic group.
`timescale 1ns/1ps
`include "feg_consts.vh"

module feg_class (
    input wire [`FEG_OP_W-1:0] op,
    input wire [1:0] memFmt,
    output reg isWaiting,
    output reg isNop,
    output reg isArith
);

    // ==========================================================
    // Decode
    // The non-waiting control forms and the obsolete no-ops skip the pending check.
    always @* begin
        isWaiting = 1'b1;
        isNop = 1'b0;
        isArith = 1'b0;
        case (op)
            `FEG_OP_STCW_N, `FEG_OP_STSW_N, `FEG_OP_STENV_N,
            `FEG_OP_SAVE_N, `FEG_OP_INIT_N, `FEG_OP_CLEX_N: begin
                isWaiting = 1'b0;
            end
            `FEG_OP_LEG_ENI, `FEG_OP_LEG_DISI, `FEG_OP_LEG_SETPM: begin
                isWaiting = 1'b0;
                isNop = 1'b1;
            end
            `FEG_OP_ARITH: begin
                isArith = 1'b1;
            end
            `FEG_OP_MOVE: begin
                // Converting memory formats are arithmetic.
                isArith = (memFmt == `FEG_FMT_SGLDBL) ||
                          (memFmt == `FEG_FMT_INTBCD);
            end
            default: begin
                isArith = 1'b0;
            end
        endcase
    end

endmodule // feg_class

// >>> testbench/feg_core_properties.sv
// Port-level checks of the exception gating core.
`timescale 1ns/1ps
`include "feg_consts.vh"

module feg_properties (
    input wire clock,
    input wire rst,
    input wire issueValid,
    input wire [`FEG_OP_W-1:0] issueOp,
    input wire [1:0] memFmt,
    input wire issueDone_q,
    input wire commit_q,
    input wire excPending_q,
    input wire handlerReq_q,
    input wire arithClass_q,
    input wire storeValid_q
);
    // ==========================================================
    // Decoded request kinds
    // Odd codes from 5 to 15 are the non-waiting control forms.
    wire noWait = issueOp[0] && issueOp >= 5'h05 && issueOp <= 5'h0F;
    wire legacy = issueOp >= 5'h14 && issueOp <= 5'h16;
    wire convFmt = memFmt[0];
    default clocking dck @(posedge clock); endclocking
    default disable iff (rst);

    // ==========================================================
    // Assertions
    chk_one_answer: assert property (
        issueValid |=> issueDone_q != excPending_q)
        else $error("Answer is not exactly one pulse.");
    chk_no_stray: assert property (
        !issueValid |=> !issueDone_q && !excPending_q)
        else $error("Answer without a request.");
    chk_nowait_runs: assert property (
        issueValid && noWait |=> issueDone_q && !excPending_q)
        else $error("Non-waiting form was stalled.");
    chk_legacy_nop: assert property (
        issueValid && legacy |=> issueDone_q && !commit_q && !storeValid_q)
        else $error("Obsolete code did not act as a no-op.");
    chk_stall_quiet: assert property (
        excPending_q |-> !commit_q && !storeValid_q && !handlerReq_q)
        else $error("Stalled instruction changed state.");
    chk_arith_group: assert property (
        issueValid && issueOp == `FEG_OP_ARITH
        |=> excPending_q || arithClass_q)
        else $error("Arithmetic kind not classed arithmetic.");
    chk_nonarith_group: assert property (
        issueValid && issueOp == `FEG_OP_NONARITH |=> !arithClass_q)
        else $error("Non-arithmetic kind classed arithmetic.");
    chk_move_group: assert property (
        issueValid && issueOp == `FEG_OP_MOVE
        |=> excPending_q || arithClass_q == $past(convFmt))
        else $error("Move format classed wrongly.");
    chk_handler_hold: assert property (
        handlerReq_q |-> issueDone_q && !commit_q)
        else $error("Handler request let the instruction commit.");
endmodule // feg_properties

bind feg_core feg_properties i_chk (.clock(clock), .rst(rst),
    .issueValid(issueValid), .issueOp(issueOp), .memFmt(memFmt),
    .issueDone_q(issueDone_q), .commit_q(commit_q),
    .excPending_q(excPending_q), .handlerReq_q(handlerReq_q),
    .arithClass_q(arithClass_q), .storeValid_q(storeValid_q));

// >>> testbench/feg_issuer.sv
// Model of the integer core that issues floating-point instructions.
`timescale 1ns/1ps

module feg_issuer (
    input wire clock,
    output reg issueValid = 1'b0,
    output reg [4:0] issueOp = 5'h00,
    output reg [1:0] memFmt = 2'h0,
    output reg pushDst = 1'b0,
    output reg [1:0] dstTag = 2'h0,
    output reg checkSrc = 1'b0,
    output reg [1:0] srcTag = 2'h0,
    output reg [5:0] numExc = 6'h00,
    output reg [15:0] loadCtrl = 16'h0000,
    output reg [15:0] loadStat = 16'h0000
);
    // Presents one instruction for one edge, then scrambles the op, exception, push and check fields.
    task send(input [4:0] o, input [1:0] f, input pu, input [1:0] dt,
              input ch, input [1:0] st, input [5:0] ex, input [15:0] ld);
        issueOp <= o;
        memFmt <= f;
        pushDst <= pu;
        dstTag <= dt;
        checkSrc <= ch;
        srcTag <= st;
        numExc <= ex;
        loadCtrl <= ld;
        loadStat <= {ld[7:0], ld[15:8]};
        issueValid <= 1'b1;
        @(posedge clock);
        issueValid <= 1'b0;
        issueOp <= ~o;
        numExc <= ~ex;
        pushDst <= ~pu;
        checkSrc <= ~ch;
    endtask
endmodule // feg_issuer

// >>> testbench/test_fpu_exception_gating.sv
// Self-checking bench of the exception gating core.
`timescale 1ns/1ps
`include "feg_consts.vh"

module test_fpu_exception_gating;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [3:0] regAddr = 4'h0;
    reg [15:0] regWdata = 16'h0000;
    reg regWr = 1'b0;
    reg regRd = 1'b0;
    wire issueValid, pushDst, checkSrc, issueDone_q, commit_q, irq_q;
    wire excPending_q, handlerReq_q, arithClass_q, storeValid_q;
    wire [4:0] issueOp;
    wire [1:0] memFmt, dstTag, srcTag;
    wire [5:0] numExc;
    wire [15:0] loadCtrl, loadStat, storeCtrl_q, storeStat_q, regRdata_q;
    integer errors = 0;
    integer numChecks = 0;
    integer cycles = 0;
    integer seed = 32'h335C;
    integer i;
    reg [5:0] flags = 6'h00;
    reg [5:0] masks = 6'h3F;
    reg sf = 1'b0;
    reg c1 = 1'b0;
    reg sk;
    reg [4:0] op;
    reg [15:0] r, q;

    feg_issuer i_iss (.clock(clock), .issueValid(issueValid),
        .issueOp(issueOp), .memFmt(memFmt), .pushDst(pushDst),
        .dstTag(dstTag), .checkSrc(checkSrc), .srcTag(srcTag),
        .numExc(numExc), .loadCtrl(loadCtrl), .loadStat(loadStat));
    feg_core i_dut (.clock(clock), .rst(rst), .issueValid(issueValid),
        .issueOp(issueOp), .memFmt(memFmt), .pushDst(pushDst),
        .dstTag(dstTag), .checkSrc(checkSrc), .srcTag(srcTag),
        .numExc(numExc), .loadCtrl(loadCtrl), .loadStat(loadStat),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .issueDone_q(issueDone_q), .commit_q(commit_q),
        .excPending_q(excPending_q), .handlerReq_q(handlerReq_q),
        .arithClass_q(arithClass_q), .storeValid_q(storeValid_q),
        .storeCtrl_q(storeCtrl_q), .storeStat_q(storeStat_q),
        .regRdata_q(regRdata_q), .irq_q(irq_q));

    // ==========================================================
    // Clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            conclude;
        end
    end

    // ==========================================================
    // Shared tasks
    // Model status word: flags, stack flag, summary, condition bit one.
    function logic [15:0] statWord();
        statWord = {6'h00, c1, 1'b0, |(flags & ~masks), sf, flags};
    endfunction
    task check(input string what, input [15:0] expv, input [15:0] got);
        numChecks = numChecks + 1;
        if (got !== expv) begin
            $display("mismatch %s expected %h seen %h", what, expv, got);
            errors = errors + 1;
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task regWrite(input [3:0] a, input [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        @(posedge clock);
    endtask
    task regRead(input [3:0] a, output [15:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        d = regRdata_q;
        @(posedge clock);
    endtask
    task irqIs(input e);
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("irq", e, irq_q);
        @(posedge clock);
    endtask
    // Issues one instruction and compares its answers with the model; the arithmetic class is compared only when not stalled.
    task step(input [4:0] o, input [1:0] fm, input pu, input [1:0] dt,
              input ch, input [1:0] st, input [5:0] ex, input [15:0] ld);
        reg nw, lg, ar, ov, un, pend, hnd, sS, sC;
        reg [15:0] sw;
        nw = o[0] && o >= 5'h05 && o <= 5'h0F;
        lg = o >= 5'h14 && o <= 5'h16;
        sw = statWord();
        pend = !nw && !lg && sw[7];
        ar = o == `FEG_OP_ARITH || (o == `FEG_OP_MOVE && fm[0]);
        ov = pu && dt != `FEG_TAG_EMPTY;
        un = ch && st == `FEG_TAG_EMPTY;
        hnd = !pend && ((ar && ex[0]) || ov || un) && !masks[0];
        sS = !pend && ((o >= 5'h06 && o <= 5'h0B) || o == `FEG_OP_XSAVE);
        sC = !pend && ((o >= 5'h04 && o <= 5'h0B && o[3:1] != 3'h3)
            || o == `FEG_OP_XSAVE);
        i_iss.send(o, fm, pu, dt, ch, st, ex, ld);
        @(negedge clock);
        check("pending", pend, excPending_q);
        check("done", !pend, issueDone_q);
        check("commit", !pend && !lg && !hnd, commit_q);
        check("handler", hnd, handlerReq_q);
        check("store", sS || sC, storeValid_q);
        if (!pend) check("arith", ar, arithClass_q);
        if (sS) check("status", sw, storeStat_q & 16'h02FF);
        if (sC) check("control", masks, storeCtrl_q[5:0]);
        if (!pend && !lg && (o <= 5'h01 || o == `FEG_OP_MOVE)) begin
            flags = flags | (ar ? ex : 6'h00) | {5'h00, ov || un};
            if (ov || un) begin
                sf = 1'b1;
                c1 = ov;
            end
        end
        if (!pend && o == `FEG_OP_LDCW) masks = ld[5:0];
        if (!pend && o >= 5'h0A && o <= 5'h0F) begin
            flags = 6'h00;
            sf = 1'b0;
        end
        if (!pend && o >= 5'h0A && o <= 5'h0D) begin
            masks = 6'h3F;
            c1 = 1'b0;
        end
        if (!pend && o >= 5'h10 && o <= 5'h12) begin
            masks = ld[5:0];
            flags = ld[13:8];
            sf = ld[14];
            c1 = ld[1];
        end
        @(posedge clock);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        regRead(`FEG_ADDR_CTRL, r);
        check("control reset", 16'h003F, r);
        regRead(4'hF, r);
        check("unmapped", 16'h0000, r);
        regWrite(`FEG_ADDR_EVMSK, 16'h0001);
        step(`FEG_OP_LDCW, 0, 0, 0, 0, 0, 0, 16'h0000);
        step(`FEG_OP_ARITH, 0, 0, 0, 0, 0, 6'h01, 0);
        step(`FEG_OP_ARITH, 0, 0, 0, 0, 0, 6'h00, 0);
        irqIs(1'b1);
        regRead(`FEG_ADDR_EVT, r);
        check("stall event", 16'h0001, r & 16'h0001);
        regWrite(`FEG_ADDR_EVMSK, 16'h0000);
        irqIs(1'b0);
        regWrite(`FEG_ADDR_EVT, 16'h0001);
        regWrite(`FEG_ADDR_EVMSK, 16'h0001);
        irqIs(1'b0);
        regWrite(`FEG_ADDR_CTRL, 16'h0100);
        step(`FEG_OP_STSW_N, 0, 0, 0, 0, 0, 0, 0);
        step(`FEG_OP_CLEX_N, 0, 0, 0, 0, 0, 0, 0);
        regWrite(`FEG_ADDR_EVT, 16'h000F);
        step(`FEG_OP_MOVE, 0, 1, 0, 0, 0, 0, 0);
        regRead(`FEG_ADDR_EVT, r);
        check("events", 16'h000E, r);
        for (i = 0; i < 24; i = i + 1) begin
            step(i[4:0], 2'h1, 0, 0, 0, 0, 6'h3F, 16'h5A00);
        end
        for (i = 0; i < 300; i = i + 1) begin
            op = {$random(seed)} % 24;
            {q, r} = $random(seed);
            sk = op <= 5'h01 || op == `FEG_OP_MOVE;
            step(op, r[1:0], sk && r[2], r[4:3], sk && r[5], r[7:6],
                r[13:8], q);
        end
        regRead(`FEG_ADDR_STAT, r);
        check("status reg", statWord(), r & 16'h02FF);
        conclude;
    end
endmodule // test_fpu_exception_gating
